// File: rtl/asf_defs.svh
// Purpose: Offsets, field positions, reset values for the receive status flags
// Assumes: Included by bare name; definitions only
// Notes:   Byte addresses on the AHB-Lite slave
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH

// Register byte offsets
`define ASF_OFS_INT_ENABLES   8'h7C
`define ASF_OFS_RX_STATUS     8'h80

// Status bit positions
`define ASF_BIT_OVERRUN       0
`define ASF_BIT_SYNC_ERR      1
`define ASF_BIT_CLOCK_FAIL    2
`define ASF_BIT_SLOT_PARITY   3
`define ASF_BIT_LAST_SLOT     4
`define ASF_BIT_DATA_READY    5
`define ASF_BIT_START_FRAME   6
`define ASF_BIT_DMA_ERR       7
`define ASF_BIT_ERR_SUMMARY   8

// Enable bit positions that differ from their flags
`define ASF_EN_START_FRAME    7
`define ASF_EN_DMA_ERR        3

// Writable enable bits (bit 6 reserved)
`define ASF_EN_WRITE_MASK     8'hBF
// Event flag bits (bit 3 is the read-only parity)
`define ASF_FLAG_MASK         8'hF7

// Reset values
`define ASF_RST_STATUS        32'h0000_0000
`define ASF_RST_ENABLES       8'h00

`endif

// File: rtl/asf_pkg.sv
// Purpose: Types shared by the receive status flag logic
// Assumes: Constants live in asf_defs.svh
// Notes:   Frame tracking state only
package asf_pkg;

  // Frame tracking state
  typedef enum logic [0:0]
  {
    ASF_WAIT_SYNC = 1'b0,   // No frame seen since enable
    ASF_IN_FRAME  = 1'b1    // Frames running, syncs are checked
  } asf_frame_state_type;

endpackage : asf_pkg

// File: rtl/asf_sync3.sv
// Purpose: Three-stage synchroniser for a pin input
// Assumes: Input is asynchronous to hclk
// Notes:   Output changes only once stages two and three agree
`timescale 1ns/1ps
module asf_sync3
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Pin side
  input  wire logic pin_in,
  // Clean side
  output logic      level_out
);

  logic s1_reg;   // First stage, read by s2 only
  logic s2_reg;   // Second stage
  logic s3_reg;   // Third stage

  // Shift chain
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a change when the last two agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      level_out <= 1'b0;
    else if (s2_reg == s3_reg)
      level_out <= s3_reg;
  end

endmodule : asf_sync3

// File: rtl/asf_flag.sv
// Purpose: One sticky write-one-to-clear event flag
// Assumes: Set and clear are single-cycle strobes on hclk
// Notes:   Set beats clear in the same cycle
`timescale 1ns/1ps
module asf_flag
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Strobes
  input  wire logic set_in,
  input  wire logic clr_in,
  // State
  output logic      flag_out
);

  // Sticky hold, clear by one, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flag_out <= 1'b0;
    else if (set_in)
      flag_out <= 1'b1;
    else if (clr_in)
      flag_out <= 1'b0;
  end

endmodule : asf_flag

// File: rtl/asf_rx_status_flags.sv
// Purpose: Receive status register, event flags, interrupt and DMA event
// Assumes: AHB-Lite single slave, word accesses, event inputs on hclk
// Notes:   Frame sync arrives from a pin and is synchronised here
// Notes:   Enable bit 3 gates the DMA error flag, bit 7 the start of frame
// Behaviour
// - Hardware set beats simultaneous software clear
// - Surviving set raises a fresh interrupt request
// - Bit 8 ORs the four error flags
// - Too many data port reads per slot
// - Write one clears, zero leaves flag
// - Enabled set flag drives receive interrupt
// - Bit 6 set on new frame sync
// - Bit 5 set on word into buffer
// - Data ready always issues DMA event
// - Bit 4 set with data on last slot
// - Bit 3 mirrors slot counter LSB
// - Bits 31 to 9 read zero
// - Bit 0 set on unread buffer overwrite
// - Bit 1 set on early frame sync
// - Bit 2 set on clock check error
`timescale 1ns/1ps
`include "asf_defs.svh"
module asf_rx_status_flags
  import asf_pkg::*;
#(
  parameter int SLOT_W  = 10,   // Slot counter width
  parameter int SER_W   = 5     // Serializer count width
)
(
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Receive section events
  input  wire logic              receiver_active,
  input  wire logic              receive_frame_sync,
  input  wire logic              buffer_transfer,
  input  wire logic              data_port_read,
  input  wire logic              slot_advance,
  input  wire logic              clock_check_error,
  // Receive configuration and slot state
  input  wire logic [SLOT_W-1:0] current_receive_slot_count,
  input  wire logic [SLOT_W-1:0] frame_slots,
  input  wire logic [SER_W-1:0]  receivers_configured,
  // Requests out
  output logic                   receive_interrupt,
  output logic                   receive_interrupt_request,
  output logic                   receive_dma_event
);

  // Bus address phase capture
  logic              wr_pend_reg;       // Write data phase pending
  logic [7:0]        wr_addr_reg;       // Offset of pending write
  logic              addr_phase;        // Valid transfer on this edge
  logic [7:0]        addr_ofs;          // Low address bits

  // Software state
  logic [7:0]        enables_reg;       // Interrupt enables
  logic [7:0]        clr_vec;           // Write-one clear strobes

  // Flags and events
  logic [7:0]        set_vec;           // Hardware set strobes per bit
  logic [7:0]        flag_vec;          // Flag states, bit 3 unused
  logic [7:0]        en_mapped;         // Enables aligned to flag bits
  logic              error_summary;     // OR of error flags
  logic [31:0]       status_word;       // Read view of status

  // Frame sync handling
  logic              fs_level;          // Synchronised frame sync
  logic              fs_prev_reg;       // Previous level for edge detect
  logic              fs_edge;           // New frame sync
  asf_frame_state_type frame_state_reg; // Frame tracking
  logic              last_slot;         // Counter on final slot

  // Buffer and data port tracking
  logic              buf_unread_reg;    // Buffer holds unread word
  logic [SER_W-1:0]  reads_reg;         // Data port reads this slot
  logic [SER_W-1:0]  reads_eff;         // Reads counted before this one

  // Bus decode
  // Only the low address byte selects a register
  assign addr_phase = hsel && htrans[1] && hready;
  assign addr_ofs   = haddr[7:0];

  // Capture write address phase
  // The write itself lands a cycle later, with hwdata
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase)
        wr_addr_reg <= addr_ofs;
    end
  end

  // Zero wait states, always OKAY
  // Held in flops so every bus output comes from a register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Enable register write, reserved bit held zero
  // Bit 3 enables the DMA error flag, bit 7 the start of frame
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      enables_reg <= `ASF_RST_ENABLES;
    else if (wr_pend_reg && wr_addr_reg == `ASF_OFS_INT_ENABLES)
      enables_reg <= hwdata[7:0] & `ASF_EN_WRITE_MASK;
  end

  // Clear strobes from a status write data phase
  // Bit 3 is read-only, so its clear strobe is masked off
  always_comb
  begin
    clr_vec = 8'h00;
    if (wr_pend_reg && wr_addr_reg == `ASF_OFS_RX_STATUS)
      clr_vec = hwdata[7:0] & `ASF_FLAG_MASK;
  end

  // Frame sync pin synchroniser
  // Pin is asynchronous, no edge is used before three stages
  asf_sync3 u_fs_sync
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pin_in    (receive_frame_sync),
    .level_out (fs_level)
  );

  // Edge detect on the clean level
  // Reset level matches the idle pin, so no false edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fs_prev_reg <= 1'b0;
    else
      fs_prev_reg <= fs_level;
  end

  assign fs_edge   = fs_level && !fs_prev_reg;
  assign last_slot = (current_receive_slot_count == (frame_slots - 1'b1));

  // Frame tracker, syncs are checked only once framing runs
  // The first sync only starts framing; later ones are checked
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      frame_state_reg <= ASF_WAIT_SYNC;
    else
    begin
      case (frame_state_reg)
        ASF_WAIT_SYNC:
        begin
          // First sync after enable starts framing
          if (receiver_active && fs_edge)
            frame_state_reg <= ASF_IN_FRAME;
        end
        ASF_IN_FRAME:
        begin
          // Disable drops back to waiting
          if (!receiver_active)
            frame_state_reg <= ASF_WAIT_SYNC;
        end
        // Unknown code falls back to waiting
        default:
          frame_state_reg <= ASF_WAIT_SYNC;
      endcase
    end
  end

  // Buffer occupancy for overrun detection
  // A new word and a read in one cycle leave the buffer full
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      buf_unread_reg <= 1'b0;
    else if (buffer_transfer)
      buf_unread_reg <= 1'b1;
    else if (data_port_read)
      buf_unread_reg <= 1'b0;
  end

  // Reads counted so far in this slot
  // A read in the slot's first cycle counts against the new slot
  assign reads_eff = slot_advance ? '0 : reads_reg;

  // Per-slot data port read counter, saturating
  // Saturation keeps a runaway DMA from wrapping back to zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      reads_reg <= '0;
    else if (data_port_read && reads_eff != {SER_W{1'b1}})
      reads_reg <= reads_eff + 1'b1;
    else
      reads_reg <= reads_eff;
  end

  // Hardware set strobes
  // One-cycle strobes; the flag cells hold the result
  always_comb
  begin
    set_vec = 8'h00;
    // Overwrite of a word nobody read
    set_vec[`ASF_BIT_OVERRUN]     = buffer_transfer && buf_unread_reg
                                    && !data_port_read;
    // Sync before the frame's last slot
    set_vec[`ASF_BIT_SYNC_ERR]    = fs_edge && !last_slot
                                    && frame_state_reg == ASF_IN_FRAME;
    // Clock check circuit error
    set_vec[`ASF_BIT_CLOCK_FAIL]  = clock_check_error;
    // Final slot word arrives
    set_vec[`ASF_BIT_LAST_SLOT]   = buffer_transfer && last_slot;
    // Word moved into buffer
    set_vec[`ASF_BIT_DATA_READY]  = buffer_transfer;
    // New frame sync
    set_vec[`ASF_BIT_START_FRAME] = fs_edge && receiver_active;
    // More reads than receivers in a slot
    set_vec[`ASF_BIT_DMA_ERR]     = data_port_read
                                    && reads_eff >= receivers_configured;
  end

  // One sticky flag per event bit
  // Bit 3 has no cell, it shows the live slot parity
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_flag
      if (gi == `ASF_BIT_SLOT_PARITY)
      begin : g_hole
        assign flag_vec[gi] = 1'b0;
      end
      else
      begin : g_cell
        asf_flag u_flag
        (
          .hclk     (hclk),
          .hresetn  (hresetn),
          .set_in   (set_vec[gi]),
          .clr_in   (clr_vec[gi]),
          .flag_out (flag_vec[gi])
        );
      end
    end
  endgenerate

  // Enables aligned to flag positions
  // Flag 6 uses enable 7 and flag 7 uses enable 3
  always_comb
  begin
    en_mapped = enables_reg & `ASF_FLAG_MASK;
    en_mapped[`ASF_BIT_START_FRAME] = enables_reg[`ASF_EN_START_FRAME];
    en_mapped[`ASF_BIT_DMA_ERR]     = enables_reg[`ASF_EN_DMA_ERR];
  end

  // Error summary
  // Combinational, so it drops as soon as the flags clear
  assign error_summary = flag_vec[`ASF_BIT_OVERRUN] | flag_vec[`ASF_BIT_SYNC_ERR]
                       | flag_vec[`ASF_BIT_CLOCK_FAIL]
                       | flag_vec[`ASF_BIT_DMA_ERR];

  // Status read view
  // Parity and summary overwrite their places in the flag view
  always_comb
  begin
    status_word = `ASF_RST_STATUS;
    status_word[7:0] = flag_vec;
    status_word[`ASF_BIT_SLOT_PARITY] = current_receive_slot_count[0];
    status_word[`ASF_BIT_ERR_SUMMARY] = error_summary;
  end

  // Read data registered at the address phase
  // Shows the status as it stood in the address cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
    begin
      case (addr_ofs)
        `ASF_OFS_RX_STATUS:   hrdata <= status_word;
        `ASF_OFS_INT_ENABLES: hrdata <= {24'h00_0000, enables_reg};
        default:              hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Interrupt level from enabled set flags
  // Follows the flags one cycle late
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      receive_interrupt <= 1'b0;
    else
      receive_interrupt <= |(flag_vec & en_mapped);
  end

  // Fresh request pulse for every enabled set, even against a clear
  // Built from the set strobes, so a clear cannot mask it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      receive_interrupt_request <= 1'b0;
    else
      receive_interrupt_request <= |(set_vec & en_mapped);
  end

  // DMA event on every data ready set, enables ignored
  // One pulse for each word moved into the buffer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      receive_dma_event <= 1'b0;
    else
      receive_dma_event <= set_vec[`ASF_BIT_DATA_READY];
  end

endmodule : asf_rx_status_flags

// File: test/asf_dma_server.sv
// Purpose: DMA side that services the latest receive DMA event with one data port read
// Assumes: One serializer configured as receiver
// Notes:   A new event during a slow wait replaces the old one
`timescale 1ns/1ps
module asf_dma_server
  import asf_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Service request and latency
  input  wire logic       receive_dma_event,
  input  wire logic [3:0] service_delay,
  // Data port read strobe
  output logic            dma_read
);
  logic [4:0] wait_reg;  // Cycles left, zero when idle

  // Count down from each event, read once at one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wait_reg <= 5'h0;
      dma_read <= 1'b0;
    end
    else
    begin
      dma_read <= (wait_reg == 5'h1);
      if (receive_dma_event)
        wait_reg <= {1'b0, service_delay} + 5'h1;
      else if (wait_reg != 5'h0)
        wait_reg <= wait_reg - 5'h1;
    end
  end
endmodule : asf_dma_server

// File: test/asf_rx_status_flags_assertions.sv
// Purpose: Port-level checks of the receive status flags
// Assumes: Enable writes land at the end of the data phase
// Notes:   Status reads and enables are shadowed from the bus
`timescale 1ns/1ps
`include "asf_defs.svh"
module asf_rx_status_checker
  import asf_pkg::*;
#(
  parameter int SLOT_W = 10  // Slot counter width
)
(
  // Clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // Bus
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  // Events and slot
  input wire logic              buffer_transfer,
  input wire logic              clock_check_error,
  input wire logic [SLOT_W-1:0] current_receive_slot_count,
  // Requests
  input wire logic              receive_interrupt,
  input wire logic              receive_interrupt_request,
  input wire logic              receive_dma_event
);
  logic       take;     // Address phase accepted
  logic       rd_q;     // Status read in data phase
  logic       en_wr_q;  // Enable write in data phase
  logic [7:0] en_q;     // Shadow of interrupt enables

  assign take = hsel && htrans[1] && hready;

  // Track bus phases and shadow the enables
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_q    <= 1'b0;
      en_wr_q <= 1'b0;
      en_q    <= 8'h00;
    end
    else
    begin
      rd_q    <= take && !hwrite && haddr[7:0] == `ASF_OFS_RX_STATUS;
      en_wr_q <= take && hwrite && haddr[7:0] == `ASF_OFS_INT_ENABLES;
      if (en_wr_q)
        en_q <= hwdata[7:0] & `ASF_EN_WRITE_MASK;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_error_summary: assert property (rd_q |-> hrdata[8] == (hrdata[7] | (|hrdata[2:0])))
    else $error("error summary bit wrong");
  a_reserved_zero: assert property (rd_q |-> hrdata[31:9] == 23'h0)
    else $error("reserved status bits not zero");
  a_slot_parity: assert property (rd_q |-> hrdata[3] == $past(current_receive_slot_count[0]))
    else $error("slot parity bit wrong");
  a_dma_event_follows: assert property (buffer_transfer |=> receive_dma_event)
    else $error("missing dma event");
  a_dma_event_cause: assert property (receive_dma_event |-> $past(buffer_transfer))
    else $error("dma event without transfer");
  a_quiet_disabled: assert property ((en_q == 8'h00)[*3] |-> !receive_interrupt && !receive_interrupt_request)
    else $error("interrupt with all enables clear");
  a_clkfail_request: assert property (en_q[2] && clock_check_error |=> receive_interrupt_request ##1 receive_interrupt)
    else $error("clock failure request missing");
  a_data_request: assert property (en_q[5] && buffer_transfer |=> receive_interrupt_request)
    else $error("data ready request missing");

  c_status_error: cover property (rd_q && hrdata[8]);
  c_data_irq: cover property (en_q[5] && buffer_transfer);
  c_clk_irq: cover property (en_q[2] && clock_check_error);
endmodule : asf_rx_status_checker

// File: test/test_audio_rx_status_flags.sv
// Purpose: Self-checking bench for the receive status flags
// Assumes: Eight slots per frame, one receiver serializer
// Notes:   Flags are modelled in the bench and compared on reads
`timescale 1ns/1ps
`include "asf_defs.svh"
module test_audio_rx_status_flags
  import asf_pkg::*;
;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, lfsr = 32'h3615_f374;
  logic [1:0]  htrans = 2'b00;
  logic        hreadyout, hresp, irq, irq_req, dma_ev, dma_read;
  logic [3:0]  ev = 4'h0, delay = 4'h0;  // Strobes: 0 xfer, 1 read, 2 slot, 3 clk err
  logic        active = 1'b0, sync_pin = 1'b0;
  logic [9:0]  slot = 10'h0;
  logic [7:0]  flags = 8'h0;  // Expected event flags
  int          fail_count = 0, compares = 0, cycles = 0;

  always #5 hclk = ~hclk;

  asf_rx_status_flags i_asf_rx_status_flags
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .receiver_active(active),
    .receive_frame_sync(sync_pin), .buffer_transfer(ev[0]), .data_port_read(ev[1] | dma_read),
    .slot_advance(ev[2]), .clock_check_error(ev[3]), .current_receive_slot_count(slot),
    .frame_slots(10'h008), .receivers_configured(5'h01), .receive_interrupt(irq),
    .receive_interrupt_request(irq_req), .receive_dma_event(dma_ev)
  );

  asf_dma_server i_asf_dma_server
  (
    .hclk(hclk), .hresetn(hresetn), .receive_dma_event(dma_ev), .service_delay(delay),
    .dma_read(dma_read)
  );

  function automatic logic [31:0] next_rand(input logic [31:0] x);
    next_rand = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : next_rand

  function automatic logic [31:0] status_exp(input logic [7:0] f, input logic s);
    status_exp = {23'h0, f[7] | (|f[2:0]), f[7:4], s, f[2:0]};
  endfunction : status_exp

  function automatic logic irq_exp(input logic [7:0] f, input logic [7:0] en);
    irq_exp = |(f & {en[3], en[7], en[5:4], 1'b0, en[2:0]});
  endfunction : irq_exp

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : check

  // One single transfer; strobes e stand in its data phase
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] e);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    ev <= e;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    ev <= 4'h0;
    @(posedge hclk);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb

  task read_status();
    ahb(1'b0, `ASF_OFS_RX_STATUS, 32'h0, 4'h0);
    check("status", status_exp(flags, slot[0]), rd);
  endtask : read_status

  task strobe(input logic [3:0] e);
    ev <= e;
    @(posedge hclk);
    ev <= 4'h0;
    repeat (4) @(posedge hclk);
  endtask : strobe

  task sync_pulse();
    sync_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    sync_pin <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask : sync_pulse

  task finish_test();
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // Cut a hang short
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      finish_test();
    end
  end

  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    read_status();
    ahb(1'b1, `ASF_OFS_INT_ENABLES, 32'hFFFF_FFFF, 4'h0);
    ahb(1'b0, `ASF_OFS_INT_ENABLES, 32'h0, 4'h0);
    check("enables", 32'h0000_00BF, rd);
    ahb(1'b1, `ASF_OFS_INT_ENABLES, 32'h0000_0024, 4'h0);
    ahb(1'b0, 32'h0000_0088, 32'h0, 4'h0);
    check("unmapped", 32'h0, rd);
    // Random transfers, clock errors and partial clears
    for (int i = 0; i < 24; i++)
    begin
      lfsr = next_rand(lfsr);
      slot <= 10'(i % 8);
      @(posedge hclk);
      strobe({lfsr[3], 2'b10, lfsr[0] | (i % 8 == 7)});
      if (lfsr[0] | (i % 8 == 7))
        flags = flags | 8'h20 | ((i % 8 == 7) ? 8'h10 : 8'h00);
      if (lfsr[3])
        flags[2] = 1'b1;
      read_status();
      check("interrupt", {31'h0, irq_exp(flags, 8'h24)}, {31'h0, irq});
      ahb(1'b1, `ASF_OFS_RX_STATUS, {24'h0, lfsr[15:8]}, 4'h0);
      flags = flags & ~lfsr[15:8];
      read_status();
    end
    // Set beats a simultaneous clear
    ahb(1'b1, `ASF_OFS_RX_STATUS, 32'h0000_00FF, 4'h0);
    flags = 8'h00;
    ahb(1'b1, `ASF_OFS_RX_STATUS, 32'h0000_0004, 4'h8);
    flags[2] = 1'b1;
    read_status();
    // Slow DMA lets a second word overwrite
    delay <= 4'hF;
    slot <= 10'h0;
    strobe(4'b0101);
    strobe(4'b0101);
    flags = flags | 8'h21;
    read_status();
    repeat (20) @(posedge hclk);
    delay <= 4'h0;
    strobe(4'b0010);
    strobe(4'b0010);
    flags[7] = 1'b1;
    read_status();
    // DMA error gated by enable 3, not by the start of frame enable
    ahb(1'b1, `ASF_OFS_INT_ENABLES, 32'h0000_0008, 4'h0);
    @(posedge hclk);
    check("interrupt", {31'h0, irq_exp(flags, 8'h08)}, {31'h0, irq});
    ahb(1'b1, `ASF_OFS_INT_ENABLES, 32'h0000_0080, 4'h0);
    @(posedge hclk);
    check("interrupt", {31'h0, irq_exp(flags, 8'h80)}, {31'h0, irq});
    // Frame syncs, the second arriving early
    active <= 1'b1;
    slot <= 10'h3;
    sync_pulse();
    sync_pulse();
    flags = flags | 8'h42;
    read_status();
    ahb(1'b1, `ASF_OFS_RX_STATUS, 32'h0000_00FF, 4'h0);
    flags = 8'h00;
    read_status();
    finish_test();
  end
endmodule : test_audio_rx_status_flags

bind asf_rx_status_flags asf_rx_status_checker #(.SLOT_W(SLOT_W)) i_asf_rx_status_checker
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .buffer_transfer(buffer_transfer), .clock_check_error(clock_check_error),
  .current_receive_slot_count(current_receive_slot_count),
  .receive_interrupt(receive_interrupt), .receive_interrupt_request(receive_interrupt_request),
  .receive_dma_event(receive_dma_event)
);
